// *** hdl/ctc_pkg.sv ***
/*
  Constants, register map and state layout of the capture trigger
  conditioner. Assumes an 8-bit register port whose addresses are the
  printed byte offsets, and a single 25 MHz system clock.
*/
package ctc_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_ENABLE   = 8'h46;
  localparam logic [7:0] ADDR_CTL_DIV  = 8'h47;
  localparam logic [7:0] ADDR_STATUS   = 8'h48;
  localparam logic [7:0] ADDR_EDGE     = 8'h49;
  localparam logic [7:0] ADDR_CAPCTRL  = 8'h52;
  localparam logic [7:0] ADDR_SEARCH   = 8'h55;
  localparam logic [7:0] ADDR_SYNC     = 8'h57;
  localparam logic [7:0] ADDR_CAPRATIO = 8'h68;

  // Value after reset of every register
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions in the edge and polarity register
  localparam int EDGE_DIV_CLEAR  = 7;
  localparam int EDGE_CTL_POL    = 6;
  localparam int EDGE_CAP_POL    = 5;
  localparam int EDGE_DPULSE_SEL = 4;
  localparam int EDGE_DTACH_SEL  = 3;
  localparam int EDGE_CAP_HALVE  = 2;
  localparam int EDGE_CAP_SEL    = 1;
  localparam int EDGE_CTL_SEL    = 0;

  // Other field positions
  localparam int STATUS_CAP_ERR  = 3;
  localparam int CAPCTRL_ERR_CLR = 1;
  localparam int SEARCH_CTL_BYP  = 5;
  localparam int SEARCH_CAP_BYP  = 4;
  localparam int SYNC_DP_FLAG    = 5;
  localparam int CAPRATIO_EXT    = 7;

  // Enable bit positions of the two single-source capture units
  localparam int EN_DRUM_TACH = 6;
  localparam int EN_CAPSTAN   = 7;

  // Mask interval in time-base tap periods
  localparam logic [3:0] MASK_PERIODS = 4'h8;

  // Complete register state of the block
  typedef struct packed {
    logic [7:0] en;
    logic [1:0] ctl_div_hi;
    logic [5:0] ctl_ratio;
    logic [2:0] status_hi;
    logic       cap_err;
    logic [2:0] drum_ratio;
    logic [6:0] edge_sel;
    logic [7:0] search;
    logic [7:0] sync_misc;
    logic       dp_flag;
    logic       ext_both;
    logic [5:0] cap_ratio;
    logic       ctl_q;
    logic       ext_q;
    logic       dp_q;
    logic       dt_q;
    logic       cap_pol_q;
    logic       cap_half;
    logic       cap_q;
    logic       tap_q;
    logic [5:0] ctl_cnt;
    logic [2:0] drum_cnt;
    logic [5:0] cap_cnt;
    logic [3:0] mask_cnt;
    logic [5:0] fifo_trig;
    logic       drum_trig;
    logic       cap_trig;
    logic [7:0] rdata;
  } ctc_state_t;

endpackage

// *** hdl/ctc_trigger_conditioner.sv ***
/*
  Trigger conditioner for the fifo, drum and capstan capture units:
  polarity, edge selection, rate division, capstan masking and gating.
  Assumes all inputs are synchronous to sys_clk and that the register
  master issues one-cycle strobes, reading data in the next cycle.
*/
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps

module ctc_trigger_conditioner #(
  parameter logic [3:0] MASK_COUNT = ctc_pkg::MASK_PERIODS
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [7:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  output logic      [7:0] bus_rdata,
  input  wire logic       remote_rise_event,
  input  wire logic       remote_fall_event,
  input  wire logic       vertical_sync_event,
  input  wire logic       control_track_input,
  input  wire logic       external_trigger_pin,
  input  wire logic       drum_pulse_input,
  input  wire logic       drum_tach_input,
  input  wire logic       capstan_tach_input,
  input  wire logic       timebase_tap_eight,
  output logic      [5:0] fifo_trigger,
  output logic            drum_trigger,
  output logic            capstan_trigger
);

  // A zero interval would make masking meaningless
  if (MASK_COUNT == 4'h0) begin : g_bad_mask
    $error("MASK_COUNT must be at least one");
  end

  ctc_pkg::ctc_state_t q;
  ctc_pkg::ctc_state_t next_q;

  logic       ctl_pol;
  logic       ctl_edge;
  logic       ctl_div;
  logic       ctl_event;
  logic       ext_edge;
  logic       dp_edge;
  logic       dt_edge;
  logic       drum_div;
  logic       cap_pol;
  logic       cap_sig;
  logic       cap_edge;
  logic       cap_div;
  logic       tap_rise;
  logic       mask_active;
  logic       cap_masked;
  logic       cap_event;
  logic       wr_edge;
  logic       err_clr;
  logic       dp_clr;

  // Edge detection and division
  always_comb begin
    next_q = q;
    // Control track path
    ctl_pol  = control_track_input ^ q.edge_sel[ctc_pkg::EDGE_CTL_POL];
    ctl_edge = (ctl_pol & ~q.ctl_q)
             | (q.edge_sel[ctc_pkg::EDGE_CTL_SEL] & ~ctl_pol & q.ctl_q);
    next_q.ctl_q = ctl_pol;
    ctl_div = ctl_edge && (q.ctl_cnt == q.ctl_ratio);
    if (ctl_edge) begin
      next_q.ctl_cnt = ctl_div ? 6'h00 : q.ctl_cnt + 6'h01;
    end
    ctl_event = q.search[ctc_pkg::SEARCH_CTL_BYP] ? ctl_edge : ctl_div;

    // External pin and drum pulse
    ext_edge = (external_trigger_pin & ~q.ext_q)
             | (q.ext_both & ~external_trigger_pin & q.ext_q);
    next_q.ext_q = external_trigger_pin;
    dp_edge = (drum_pulse_input & ~q.dp_q)
            | (q.edge_sel[ctc_pkg::EDGE_DPULSE_SEL] & ~drum_pulse_input & q.dp_q);
    next_q.dp_q = drum_pulse_input;

    // Drum tach: one edge polarity only
    dt_edge = q.edge_sel[ctc_pkg::EDGE_DTACH_SEL] ? (~drum_tach_input & q.dt_q)
                                                   : (drum_tach_input & ~q.dt_q);
    next_q.dt_q = drum_tach_input;
    drum_div = dt_edge && (q.drum_cnt == q.drum_ratio);
    if (dt_edge) begin
      next_q.drum_cnt = drum_div ? 3'h0 : q.drum_cnt + 3'h1;
    end

    // Capstan tach: polarity, optional halving, edge select
    cap_pol = capstan_tach_input ^ q.edge_sel[ctc_pkg::EDGE_CAP_POL];
    next_q.cap_pol_q = cap_pol;
    if (cap_pol && !q.cap_pol_q) begin
      next_q.cap_half = ~q.cap_half;
    end
    cap_sig  = q.edge_sel[ctc_pkg::EDGE_CAP_HALVE] ? q.cap_half : cap_pol;
    cap_edge = (cap_sig & ~q.cap_q)
             | (~q.edge_sel[ctc_pkg::EDGE_CAP_SEL] & ~cap_sig & q.cap_q);
    next_q.cap_q = cap_sig;
    cap_div = cap_edge && (q.cap_cnt == q.cap_ratio);
    if (cap_edge) begin
      next_q.cap_cnt = cap_div ? 6'h00 : q.cap_cnt + 6'h01;
    end

    // Mask interval counted on rising edges of the time-base tap
    tap_rise    = timebase_tap_eight & ~q.tap_q;
    next_q.tap_q = timebase_tap_eight;
    mask_active = (q.mask_cnt != 4'h0);
    cap_masked  = 1'b0;
    cap_event   = 1'b0;
    if (q.search[ctc_pkg::SEARCH_CAP_BYP]) begin
      // Bypass drops any interval in progress
      cap_event       = cap_div;
      next_q.mask_cnt = 4'h0;
    end else if (cap_div && mask_active) begin
      cap_masked = 1'b1;
      if (tap_rise) begin
        next_q.mask_cnt = q.mask_cnt - 4'h1;
      end
    end else if (cap_div) begin
      cap_event       = 1'b1;
      next_q.mask_cnt = MASK_COUNT;
    end else if (tap_rise && mask_active) begin
      next_q.mask_cnt = q.mask_cnt - 4'h1;
    end

    // Gated trigger lines, one per source
    next_q.fifo_trig = {dp_edge, ext_edge, ctl_event, vertical_sync_event,
                        remote_fall_event, remote_rise_event} & q.en[5:0];
    next_q.drum_trig = drum_div & q.en[ctc_pkg::EN_DRUM_TACH];
    next_q.cap_trig  = cap_event & q.en[ctc_pkg::EN_CAPSTAN];

    // Register writes
    wr_edge = bus_wr && (bus_addr == ctc_pkg::ADDR_EDGE);
    err_clr = bus_wr && (bus_addr == ctc_pkg::ADDR_CAPCTRL)
                     && bus_wdata[ctc_pkg::CAPCTRL_ERR_CLR];
    dp_clr  = bus_wr && (bus_addr == ctc_pkg::ADDR_SYNC)
                     && bus_wdata[ctc_pkg::SYNC_DP_FLAG];
    if (bus_wr) begin
      unique case (bus_addr)
        ctc_pkg::ADDR_ENABLE: begin
          next_q.en = bus_wdata;
        end
        ctc_pkg::ADDR_CTL_DIV: begin
          next_q.ctl_div_hi = bus_wdata[7:6];
          next_q.ctl_ratio  = bus_wdata[5:0];
        end
        ctc_pkg::ADDR_STATUS: begin
          // Bit 7 is reserved and bit 3 is the read-only error flag
          next_q.status_hi  = bus_wdata[6:4];
          next_q.drum_ratio = bus_wdata[2:0];
        end
        ctc_pkg::ADDR_EDGE: begin
          next_q.edge_sel = bus_wdata[6:0];
        end
        ctc_pkg::ADDR_SEARCH: begin
          next_q.search = bus_wdata;
        end
        ctc_pkg::ADDR_SYNC: begin
          // Flag bit is write-one-to-clear; bits 7 and 1 stay zero
          next_q.sync_misc = bus_wdata & 8'h5d;
        end
        ctc_pkg::ADDR_CAPRATIO: begin
          next_q.ext_both  = bus_wdata[ctc_pkg::CAPRATIO_EXT];
          next_q.cap_ratio = bus_wdata[5:0];
        end
        default: begin
        end
      endcase
    end

    // One-shot divider clear wins over the edge that lands with it
    if (wr_edge && bus_wdata[ctc_pkg::EDGE_DIV_CLEAR]) begin
      next_q.drum_cnt   = 3'h0;
      next_q.drum_ratio = 3'h0;
    end

    // Sticky flags: a new event beats a clear in the same cycle
    next_q.dp_flag = dp_edge | (q.dp_flag & ~dp_clr);
    next_q.cap_err = cap_masked | (q.cap_err & ~err_clr);

    // Read data stand for exactly one cycle after the strobe
    next_q.rdata = 8'h00;
    if (bus_rd) begin
      unique case (bus_addr)
        ctc_pkg::ADDR_ENABLE:   next_q.rdata = q.en;
        ctc_pkg::ADDR_CTL_DIV:  next_q.rdata = {q.ctl_div_hi, q.ctl_ratio};
        ctc_pkg::ADDR_STATUS:   next_q.rdata = {1'b0, q.status_hi, q.cap_err, q.drum_ratio};
        ctc_pkg::ADDR_EDGE:     next_q.rdata = {1'b0, q.edge_sel};
        ctc_pkg::ADDR_SEARCH:   next_q.rdata = q.search;
        ctc_pkg::ADDR_SYNC:     next_q.rdata = q.sync_misc | {2'b00, q.dp_flag, 5'b00000};
        ctc_pkg::ADDR_CAPRATIO: next_q.rdata = {q.ext_both, 1'b0, q.cap_ratio};
        default:                next_q.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from the state register
  assign bus_rdata       = q.rdata;
  assign fifo_trigger    = q.fifo_trig;
  assign drum_trigger    = q.drum_trig;
  assign capstan_trigger = q.cap_trig;

  // Checks on the conditioner's own behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_fifo_gate_rise: assert property (
    fifo_trigger[0] |-> $past(remote_rise_event) && $past(q.en[0]))
    else $error("remote rise trigger without enable or event");

  chk_ctl_rise_path: assert property (
    (q.search[ctc_pkg::SEARCH_CTL_BYP] && q.en[3] && $stable(q.edge_sel)
     && $rose(control_track_input ^ q.edge_sel[ctc_pkg::EDGE_CTL_POL]))
    |=> fifo_trigger[3])
    else $error("control track rising edge not forwarded");

  chk_ctl_fall_only: assert property (
    (q.search[ctc_pkg::SEARCH_CTL_BYP] && !q.edge_sel[ctc_pkg::EDGE_CTL_SEL]
     && !q.edge_sel[ctc_pkg::EDGE_CTL_POL] && $stable(q.edge_sel)
     && $fell(control_track_input)) |=> !fifo_trigger[3])
    else $error("control track falling edge passed in rising mode");

  chk_ext_fall_only: assert property (
    (!q.ext_both && $stable(q.ext_both) && $fell(external_trigger_pin))
    |=> !fifo_trigger[4])
    else $error("external falling edge passed in rising mode");

  chk_drum_flag_set: assert property (
    dp_edge |=> q.dp_flag)
    else $error("drum pulse flag not set on edge");

  chk_drum_div_ratio: assert property (
    drum_trigger |-> $past(q.drum_cnt) == $past(q.drum_ratio))
    else $error("drum trigger before ratio count reached");

  chk_drum_div_clear: assert property (
    (wr_edge && bus_wdata[ctc_pkg::EDGE_DIV_CLEAR])
    |=> q.drum_ratio == 3'h0 && q.drum_cnt == 3'h0)
    else $error("divider clear did not zero drum count and ratio");

  chk_mask_load: assert property (
    (capstan_trigger && !$past(q.search[ctc_pkg::SEARCH_CAP_BYP]))
    |-> q.mask_cnt == MASK_COUNT)
    else $error("mask interval not started by capstan event");

  chk_cap_masked: assert property (
    (cap_div && mask_active && !q.search[ctc_pkg::SEARCH_CAP_BYP])
    |=> !capstan_trigger && q.cap_err)
    else $error("masked capstan event forwarded or error missing");

  chk_err_clear: assert property (
    (err_clr && !cap_masked) |=> !q.cap_err)
    else $error("capstan error flag not cleared");

  chk_drum_single: assert property (
    drum_trigger |=> !drum_trigger)
    else $error("drum trigger longer than one cycle");

  // Control track divider and its bypass
  chk_ctl_bypass_pass: assert property (
    (ctl_edge && q.search[ctc_pkg::SEARCH_CTL_BYP] && q.en[3])
    |=> fifo_trigger[3])
    else $error("bypassed control track edge not forwarded");

  chk_ctl_div_hit: assert property (
    (ctl_edge && !q.search[ctc_pkg::SEARCH_CTL_BYP] && q.en[3]
     && q.ctl_cnt == q.ctl_ratio) |=> fifo_trigger[3])
    else $error("control track divider missed its ratio");

  chk_ctl_div_hold: assert property (
    (ctl_edge && !q.search[ctc_pkg::SEARCH_CTL_BYP] && q.ctl_cnt != q.ctl_ratio)
    |=> !fifo_trigger[3])
    else $error("control track edge passed before ratio reached");

  chk_ctl_restart: assert property (
    (ctl_edge && q.ctl_cnt == q.ctl_ratio) |=> q.ctl_cnt == 6'h00)
    else $error("control track divider did not restart");

  chk_ctl_line: assert property (
    fifo_trigger[3] |-> $past(ctl_edge))
    else $error("control track line fired without an edge");

  // Remote and sync events keep their own lines
  chk_fall_line: assert property (
    fifo_trigger[1] |-> $past(remote_fall_event) && $past(q.en[1]))
    else $error("remote fall line fired without its event");

  chk_vsync_line: assert property (
    fifo_trigger[2] |-> $past(vertical_sync_event) && $past(q.en[2]))
    else $error("vertical sync line fired without its event");

  // Pin and drum pulse edge modes
  chk_ext_both_edges: assert property (
    (q.ext_both && q.en[4] && external_trigger_pin != q.ext_q) |=> fifo_trigger[4])
    else $error("external edge lost in both-edge mode");

  chk_dp_both_edges: assert property (
    (q.edge_sel[ctc_pkg::EDGE_DPULSE_SEL] && q.en[5] && drum_pulse_input != q.dp_q)
    |=> fifo_trigger[5])
    else $error("drum pulse edge lost in both-edge mode");

  chk_dp_rise_only: assert property (
    (!q.edge_sel[ctc_pkg::EDGE_DPULSE_SEL] && !drum_pulse_input && q.dp_q)
    |=> !fifo_trigger[5])
    else $error("drum pulse falling edge passed in rising mode");

  chk_dp_flag_hold: assert property (
    (q.dp_flag && !dp_clr) |=> q.dp_flag)
    else $error("drum pulse flag dropped without clear");

  chk_dp_flag_clear: assert property (
    (dp_clr && !dp_edge) |=> !q.dp_flag)
    else $error("drum pulse flag not cleared by write");

  // Drum tach edge choice and gating
  chk_dtach_fall_only: assert property (
    (q.edge_sel[ctc_pkg::EDGE_DTACH_SEL] && drum_tach_input && !q.dt_q) |-> !dt_edge)
    else $error("drum tach rising edge seen in falling mode");

  chk_drum_gate: assert property (
    drum_trigger |-> $past(q.en[ctc_pkg::EN_DRUM_TACH]))
    else $error("drum trigger while disabled");

  // Capstan shaping, division and masking
  chk_cap_pol_rise: assert property (
    (!q.edge_sel[ctc_pkg::EDGE_CAP_HALVE] && q.edge_sel[ctc_pkg::EDGE_CAP_SEL]
     && $stable(q.edge_sel)
     && $rose(capstan_tach_input ^ q.edge_sel[ctc_pkg::EDGE_CAP_POL])) |-> cap_edge)
    else $error("capstan rising edge lost after polarity");

  chk_cap_halve_src: assert property (
    (q.edge_sel[ctc_pkg::EDGE_CAP_HALVE] && $stable(q.edge_sel) && cap_edge)
    |-> $past(cap_pol) && !$past(q.cap_pol_q))
    else $error("halved capstan edge without an input rise");

  chk_cap_rise_only: assert property (
    (q.edge_sel[ctc_pkg::EDGE_CAP_SEL] && cap_edge) |-> cap_sig)
    else $error("capstan falling edge seen in rising mode");

  chk_cap_both_edges: assert property (
    (!q.edge_sel[ctc_pkg::EDGE_CAP_SEL] && !cap_sig && q.cap_q) |-> cap_edge)
    else $error("capstan falling edge lost in both-edge mode");

  chk_cap_restart: assert property (
    (cap_edge && q.cap_cnt == q.cap_ratio) |=> q.cap_cnt == 6'h00)
    else $error("capstan divider did not restart");

  chk_cap_bypass_pass: assert property (
    (cap_div && q.search[ctc_pkg::SEARCH_CAP_BYP] && q.en[ctc_pkg::EN_CAPSTAN])
    |=> capstan_trigger && q.mask_cnt == 4'h0)
    else $error("bypassed capstan event not forwarded");

  chk_mask_count_down: assert property (
    (tap_rise && mask_active && !q.search[ctc_pkg::SEARCH_CAP_BYP])
    |=> q.mask_cnt == $past(q.mask_cnt) - 4'h1)
    else $error("mask counter missed a time-base tap");

  chk_mask_hold: assert property (
    (!tap_rise && mask_active && !q.search[ctc_pkg::SEARCH_CAP_BYP])
    |=> $stable(q.mask_cnt))
    else $error("mask counter moved without a time-base tap");

  chk_err_hold: assert property (
    (q.cap_err && !err_clr) |=> q.cap_err)
    else $error("capstan error flag dropped without clear");

  chk_cap_gate: assert property (
    capstan_trigger |-> $past(q.en[ctc_pkg::EN_CAPSTAN]))
    else $error("capstan trigger while disabled");

  cov_ctl_trigger: cover property (fifo_trigger[3]);
  cov_cap_masked:  cover property (cap_masked ##1 q.cap_err);
  cov_drum_div8:   cover property (drum_trigger && q.drum_ratio == 3'h7);
  cov_dp_clear:    cover property (q.dp_flag ##1 dp_clr ##1 !q.dp_flag);
  cov_mask_expire: cover property (tap_rise && q.mask_cnt == 4'h1);

endmodule

// *** sim/ctc_tape_model.sv ***
/*
  Tape transport model: level sources for the trigger inputs.
  Assumes one-cycle toggle requests from the bench on sys_clk.
*/
`timescale 1ns/1ps

module ctc_tape_model (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [5:0] toggle_req,
  output logic      [5:0] level
);
  logic [5:0] held;

  // A level may change only after standing two clocks, else the edge could be missed
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      level <= 6'h00;
      held  <= 6'h3f;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (toggle_req[i] && held[i]) begin
          level[i] <= ~level[i];
          held[i]  <= 1'b0;
        end else begin
          held[i] <= 1'b1;
        end
      end
    end
  end
endmodule

// *** sim/capture_trigger_conditioner_test.sv ***
/*
  Self-checking bench: random configurations and traffic, then drum
  divider clear and capstan mask corners. Assumes package and model.
*/
`timescale 1ns/1ps

module capture_trigger_conditioner_test;
  logic        sys_clk   = 1'b0;
  logic        reset     = 1'b1;
  logic [7:0]  bus_addr  = 8'h00;
  logic [7:0]  bus_wdata = 8'h00;
  logic        bus_wr    = 1'b0;
  logic        bus_rd    = 1'b0;
  logic [2:0]  ev        = 3'h0;
  logic [5:0]  treq      = 6'h00;
  logic [31:0] seed      = 32'h1bf17dc0;
  logic [7:0]  bus_rdata;
  logic [5:0]  lvl;
  logic [5:0]  fifo_trigger;
  logic        drum_trigger;
  logic        capstan_trigger;
  logic [31:0] r;
  logic [7:0]  en;
  logic [6:0]  eg;
  logic [5:0]  ml;
  logic [4:0]  pv;
  logic [2:0]  cr, dr, kr;
  logic        xe, byp, h, pcc, c;
  int          cnt [8];
  int          base [8];
  int          x [8];
  int          n [5];
  int          ne [3];
  int          mismatches = 0;
  int          num_checks = 0;
  int          cycles     = 0;
  wire logic [7:0] outs = {capstan_trigger, drum_trigger, fifo_trigger};

  ctc_trigger_conditioner ctc_trigger_conditioner_i (
    .sys_clk(sys_clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .remote_rise_event(ev[0]), .remote_fall_event(ev[1]), .vertical_sync_event(ev[2]),
    .control_track_input(lvl[0]), .external_trigger_pin(lvl[1]),
    .drum_pulse_input(lvl[2]), .drum_tach_input(lvl[3]), .capstan_tach_input(lvl[4]),
    .timebase_tap_eight(lvl[5]), .fifo_trigger(fifo_trigger),
    .drum_trigger(drum_trigger), .capstan_trigger(capstan_trigger));

  ctc_tape_model ctc_tape_model_i (
    .sys_clk(sys_clk), .reset(reset), .toggle_req(treq), .level(lvl));

  // 25 MHz clock
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  // Pulse tally per output, plus a hang guard well above the planned run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 12000) begin
      mismatches++;
      finish_test();
    end
    for (int k = 0; k < 8; k++) begin
      cnt[k] += (outs[k] === 1'b1) ? 1 : 0;
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Edge qualifier: mode 0 rising, 1 both, 2 falling
  function automatic int edg(input logic p, input logic q, input int mode);
    return (mode == 0) ? int'(!p && q) : (mode == 1) ? int'(p != q) : int'(p && !q);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 check({24'h0, bus_rdata}, {24'h0, e});
  endtask

  // Reset between scenarios so divider residue never leaks across
  task automatic restart();
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1 base = cnt;
  endtask

  // Spacing of four clocks keeps every level within its minimum hold
  task automatic step(input logic [5:0] t, input logic [2:0] e);
    @(posedge sys_clk);
    treq <= t;
    ev   <= e;
    @(posedge sys_clk);
    treq <= 6'h00;
    ev   <= 3'h0;
    repeat (2) @(posedge sys_clk);
  endtask

  // Reference edge counts from the model levels and the configuration
  task automatic adv();
    c = ml[0] ^ eg[6];
    n[0] += edg(pv[0], c, int'(eg[0]));
    n[1] += edg(pv[1], ml[1], int'(xe));
    n[2] += edg(pv[2], ml[2], int'(eg[4]));
    n[3] += edg(pv[3], ml[3], eg[3] ? 2 : 0);
    pv[3:0] = {ml[3:1], c};
    c = ml[4] ^ eg[5];
    h = (c && !pcc) ? !h : h;
    pcc = c;
    c = eg[2] ? h : c;
    n[4] += edg(pv[4], c, eg[1] ? 0 : 1);
    pv[4] = c;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    wr(8'h00, 8'hff);
    foreach (x[i]) begin
      rd(8'h00 + 8'(i), 8'h00);
    end
    rd(8'h46, 8'h00);
    rd(8'h49, 8'h00);
    rd(8'h52, 8'h00);
    for (int it = 0; it < 12; it++) begin
      restart();
      r = rnd();
      {byp, kr, xe, eg, dr, cr, en} = r[25:0];
      wr(8'h46, en);
      wr(8'h47, {5'h00, cr});
      wr(8'h48, {5'h00, dr});
      wr(8'h55, {2'h0, byp, 5'h10});
      wr(8'h68, {xe, 4'h0, kr});
      wr(8'h49, {1'b0, eg});
      {ml, pv, h, pcc} = '0;
      n  = '{default: 0};
      ne = '{default: 0};
      adv();
      repeat (24) begin
        r = rnd();
        step({1'b0, r[4:0]}, r[7:5]);
        ml = ml ^ {1'b0, r[4:0]};
        for (int j = 0; j < 3; j++) begin
          ne[j] += int'(r[5 + j]);
        end
        adv();
      end
      repeat (6) @(posedge sys_clk);
      #1;
      x = '{ne[0], ne[1], ne[2], byp ? n[0] : n[0] / (int'(cr) + 1), n[1], n[2],
            n[3] / (int'(dr) + 1), n[4] / (int'(kr) + 1)};
      for (int k = 0; k < 8; k++) begin
        check(32'(cnt[k] - base[k]), en[k] ? 32'(x[k]) : 32'h0);
      end
      wr(8'h57, 8'h00);
      rd(8'h57, {2'h0, n[2] > 0, 5'h00});
      wr(8'h57, 8'h20);
      rd(8'h57, 8'h00);
      rd(8'h46, en);
      rd(8'h49, {1'b0, eg});
      rd(8'h68, {xe, 4'h0, kr});
      rd(8'h48, {5'h00, dr});
    end
    // Drum divider clear in mid-count
    restart();
    wr(8'h46, 8'h40);
    wr(8'h48, 8'h03);
    repeat (4) step(6'h08, 3'h0);
    wr(8'h49, 8'h80);
    rd(8'h48, 8'h00);
    rd(8'h49, 8'h00);
    repeat (4) step(6'h08, 3'h0);
    repeat (4) @(posedge sys_clk);
    #1 check(32'(cnt[6] - base[6]), 32'h2);
    // Capstan mask: event inside the interval, still masked after seven tap periods, passed after eight
    restart();
    wr(8'h46, 8'h80);
    wr(8'h49, 8'h02);
    repeat (3) step(6'h10, 3'h0);
    rd(8'h48, 8'h08);
    wr(8'h52, 8'h02);
    rd(8'h48, 8'h00);
    rd(8'h52, 8'h00);
    repeat (14) step(6'h20, 3'h0);
    repeat (2) step(6'h10, 3'h0);
    #1 check(32'(cnt[7] - base[7]), 32'h1);
    repeat (2) step(6'h20, 3'h0);
    repeat (2) step(6'h10, 3'h0);
    repeat (4) @(posedge sys_clk);
    #1 check(32'(cnt[7] - base[7]), 32'h2);
    wr(8'h55, 8'h10);
    repeat (4) step(6'h10, 3'h0);
    repeat (4) @(posedge sys_clk);
    #1 check(32'(cnt[7] - base[7]), 32'h4);
    finish_test();
  end
endmodule
